// ### include/sss_pkg.sv
// Purpose: constants and types for the sequence set stepper
// Assumes: 100 MHz pclk, APB register access, 32-bit data
// Notes:   offsets are byte addresses of aligned words
// Behaviour
// - switching the sequencer on loads stored set 0 into the active set
// - step commands advance only to the following set index, wrapping after the last
// - rewind commands, like a step on the last index, return the cycle to the first set
// - a step on the last configured index wraps to index zero
// - each accepted frame trigger uses the current active set as is
// - a pending step leaves the active set untouched until it acts
// - a step loads the next index's stored set into the active set
// - a rewind loads stored set 0 into the active set
// - during a set load, waiting status drops and triggers are ignored
// - switching off mid-frame finishes the frame, then cycling stops
// - switching off restores the active set saved at switch-on
// - up to 64 stored sets, numbered from zero
package sss_pkg;
   // timing
   localparam int CLK_NS    = 10;
   localparam int LOAD_NS   = 200;
   localparam int LOAD_CYC  = (LOAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int FRAME_NS  = 20000;
   localparam int FRAME_CYC = FRAME_NS / CLK_NS;
   // geometry
   localparam int MAX_SETS = 64;
   localparam int IDX_W    = 6;
   localparam int PW       = 32;
   localparam int CNT_W    = 12;
   // register offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_TOTAL = 8'h04;
   localparam logic [7:0] OFS_STAT  = 8'h08;
   localparam logic [7:0] OFS_SIDX  = 8'h0c;
   localparam logic [7:0] OFS_SDATA = 8'h10;
   localparam logic [7:0] OFS_ACT   = 8'h14;
   // control bits
   localparam int CTRL_ON   = 0;
   localparam int CTRL_STEP = 1;
   localparam int CTRL_REW  = 2;
   // status bits
   localparam int STAT_WAIT  = 0;
   localparam int STAT_LOAD  = 1;
   localparam int STAT_FRAME = 2;
   localparam int STAT_SEQ   = 3;
   localparam int STAT_IDX   = 8;
   // reset values
   localparam logic [6:0]    RST_TOTAL = 7'h01;
   localparam logic [PW-1:0] RST_ACT   = 32'h0000_0000;

   typedef enum {ST_WAIT, ST_LOAD, ST_FRAME} sss_state_e;

   // what a captured frame was taken with
   typedef struct packed {
      logic [IDX_W-1:0] idx;
      logic [PW-1:0]    params;
   } sss_frame_s;
endpackage

// ### rtl/sss_stepper.sv
// Purpose: steps stored parameter sets into the active set on
//          step and rewind commands written over the APB port
// Assumes: frame trigger pin is asynchronous to pclk
// Notes:   commands act only between frames, never mid-frame
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module sss_stepper #(
   parameter int NSETS = sss_pkg::MAX_SETS
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // trigger pin and frame side
   input  wire logic                  frame_trig,
   output logic                       wait_trig,
   output logic                       frame_start,
   output logic                       frame_busy,
   output sss_pkg::sss_frame_s        frame_info,
   output logic [sss_pkg::PW-1:0]     active_params
);
   localparam int IW = sss_pkg::IDX_W;
   localparam int CW = sss_pkg::CNT_W;

   sss_pkg::sss_state_e st_q, st_d;
   logic [CW-1:0]       cnt_q;
   logic [IW-1:0]       idx_q, tgt_q, sidx_q;
   logic [6:0]          total_q;
   logic [sss_pkg::PW-1:0] act_q, bak_q;
   logic [sss_pkg::PW-1:0] mem [NSETS];
   logic                on_q, seq_q;
   logic                step_q, rew_q;
   logic                s1_q, s2_q, s3_q;
   logic [31:0]         rd_q;
   logic                rdy_q, err_q;
   logic                wt_q, fs_q, fb_q;
   sss_pkg::sss_frame_s fi_q;

   // trigger pin synchroniser; s1 feeds s2 only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= frame_trig;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // bus decode
   wire acc    = psel & penable & rdy_q;
   wire wr     = acc & pwrite;
   wire a_ctrl = paddr == sss_pkg::OFS_CTRL;
   wire a_tot  = paddr == sss_pkg::OFS_TOTAL;
   wire a_stat = paddr == sss_pkg::OFS_STAT;
   wire a_sidx = paddr == sss_pkg::OFS_SIDX;
   wire a_sdat = paddr == sss_pkg::OFS_SDATA;
   wire a_act  = paddr == sss_pkg::OFS_ACT;
   wire mapped = a_ctrl | a_tot | a_stat | a_sidx | a_sdat | a_act;
   wire ctl_wr = wr & a_ctrl;
   // stored sets and active set are only edited with the sequencer idle
   wire idle   = ~seq_q & ~on_q;
   wire mem_wr = wr & a_sdat & idle;
   wire act_wr = wr & a_act & idle & (st_q != sss_pkg::ST_LOAD);

   // sequencer decisions, all taken while waiting
   wire in_wait = st_q == sss_pkg::ST_WAIT;
   wire go_on   = in_wait & on_q & ~seq_q;
   wire go_off  = in_wait & ~on_q & seq_q;
   wire go_rew  = in_wait & on_q & seq_q & rew_q;
   wire go_step = in_wait & on_q & seq_q & step_q & ~rew_q;
   wire go_load = go_on | go_rew | go_step;
   wire trg     = s2_q & ~s3_q;
   wire trig_ok = trg & in_wait & ~go_load & ~go_off;
   wire ld_end  = (st_q == sss_pkg::ST_LOAD) &
                  (cnt_q == CW'(sss_pkg::LOAD_CYC - 1));
   wire fr_end  = (st_q == sss_pkg::ST_FRAME) &
                  (cnt_q == CW'(sss_pkg::FRAME_CYC - 1));
   wire last    = {1'b0, idx_q} + 7'h01 >= total_q;
   wire [IW-1:0] nxt = last ? '0 : idx_q + 1'b1;
   wire [IW-1:0] tgt = go_step ? nxt : '0;
   // a command written in the cycle it is consumed survives
   wire step_d = (ctl_wr & pwdata[sss_pkg::CTRL_STEP] & on_q) |
                 (step_q & ~go_step & ~go_rew & ~go_on & ~go_off);
   wire rew_d  = (ctl_wr & pwdata[sss_pkg::CTRL_REW] & on_q) |
                 (rew_q & ~go_rew & ~go_on & ~go_off);
   wire [6:0] tot_w = (pwdata[31:0] == 32'h0000_0000) ? 7'h01 :
                      (pwdata[31:0] > 32'(NSETS)) ? 7'(NSETS) :
                      pwdata[6:0];

   // next state
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         sss_pkg::ST_WAIT: begin
            if (go_load) begin
               st_d = sss_pkg::ST_LOAD;
            end else if (trig_ok) begin
               st_d = sss_pkg::ST_FRAME;
            end
         end
         sss_pkg::ST_LOAD: begin
            if (ld_end) begin
               st_d = sss_pkg::ST_WAIT;
            end
         end
         sss_pkg::ST_FRAME: begin
            if (fr_end) begin
               st_d = sss_pkg::ST_WAIT;
            end
         end
      endcase
   end

   // state and shared cycle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q  <= sss_pkg::ST_WAIT;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= (st_d != st_q || in_wait) ? '0 : cnt_q + 1'b1;
      end
   end

   // command flags and on switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q   <= 1'b0;
         step_q <= 1'b0;
         rew_q  <= 1'b0;
      end else begin
         if (ctl_wr) begin
            on_q <= pwdata[sss_pkg::CTRL_ON];
         end
         step_q <= step_d;
         rew_q  <= rew_d;
      end
   end

   // sequence position and backup of the pre-sequencer set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_q <= 1'b0;
         idx_q <= '0;
         tgt_q <= '0;
         bak_q <= sss_pkg::RST_ACT;
      end else begin
         if (go_on) begin
            seq_q <= 1'b1;
            bak_q <= act_q;
         end else if (go_off) begin
            seq_q <= 1'b0;
         end
         if (go_load) begin
            tgt_q <= tgt;
         end
         if (ld_end) begin
            idx_q <= tgt_q;
         end
      end
   end

   // active set: a load, a restore or a software edit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= sss_pkg::RST_ACT;
      end else if (ld_end) begin
         act_q <= mem[tgt_q];
      end else if (go_off) begin
         act_q <= bak_q;
      end else if (act_wr) begin
         act_q <= pwdata;
      end
   end

   // stored sets; no reset, so a set never written reads unknown
   always_ff @(posedge pclk) begin
      if (mem_wr) begin
         mem[sidx_q] <= pwdata[sss_pkg::PW-1:0];
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         total_q <= sss_pkg::RST_TOTAL;
         sidx_q  <= '0;
      end else begin
         if (wr & a_tot & idle) begin
            total_q <= tot_w;
         end
         if (wr & a_sidx) begin
            sidx_q <= pwdata[IW-1:0];
         end
      end
   end

   // read mux
   wire [31:0] stat_w = {
      16'h0000, 2'b00, idx_q, 4'h0, seq_q,
      st_q == sss_pkg::ST_FRAME,
      st_q == sss_pkg::ST_LOAD, wt_q};
   wire [31:0] rd_w =
      a_ctrl ? {29'h0, rew_q, step_q, on_q} :
      a_tot  ? {25'h0, total_q} :
      a_stat ? stat_w :
      a_sidx ? {26'h0, sidx_q} :
      a_sdat ? 32'(mem[sidx_q]) :
      a_act  ? 32'(act_q) : 32'h0000_0000;

   // no wait state: ready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rd_q  <= 32'h0000_0000;
      end else begin
         rdy_q <= psel & ~penable;
         err_q <= psel & ~penable & ~mapped;
         if (psel & ~penable) begin
            rd_q <= pwrite ? 32'h0000_0000 : rd_w;
         end
      end
   end

   // frame side outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wt_q <= 1'b1;
         fs_q <= 1'b0;
         fb_q <= 1'b0;
         fi_q <= '0;
      end else begin
         wt_q <= st_d == sss_pkg::ST_WAIT;
         fs_q <= trig_ok;
         fb_q <= st_d == sss_pkg::ST_FRAME;
         if (trig_ok) begin
            fi_q <= '{idx: idx_q, params: act_q};
         end
      end
   end

   assign prdata        = rd_q;
   assign pready        = rdy_q;
   assign pslverr       = err_q;
   assign wait_trig     = wt_q;
   assign frame_start   = fs_q;
   assign frame_busy    = fb_q;
   assign frame_info    = fi_q;
   assign active_params = act_q;

   // checks
   sequence s_load_gap;
      !wt_q [*8];
   endsequence

   property p_load_gap;
      @(posedge pclk) disable iff (!presetn)
      go_load |=> s_load_gap;
   endproperty

   a_load_drops_wait: assert property (p_load_gap)
      else $error("waiting status shown during set load");

   a_trig_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      trg && st_q == sss_pkg::ST_LOAD |=> !fs_q)
      else $error("trigger accepted during set load");

   a_on_loads_zero: assert property (@(posedge pclk) disable iff (!presetn)
      go_on |-> ##21 (idx_q == 6'h00 && wt_q))
      else $error("switch-on did not load set 0");

   a_rewind_zero: assert property (@(posedge pclk) disable iff (!presetn)
      go_rew |-> ##21 (idx_q == 6'h00))
      else $error("rewind did not load set 0");

   a_step_wraps: assert property (@(posedge pclk) disable iff (!presetn)
      go_step && last |-> ##21 (idx_q == 6'h00))
      else $error("step on last set did not wrap");

   a_step_next: assert property (@(posedge pclk) disable iff (!presetn)
      go_step && !last |-> ##21 (idx_q == $past(idx_q, 21) + 6'h01))
      else $error("step did not load next set");

   a_active_held: assert property (@(posedge pclk) disable iff (!presetn)
      !ld_end && !go_off && !act_wr |=> act_q == $past(act_q))
      else $error("active set changed without cause");

   a_frame_params: assert property (@(posedge pclk) disable iff (!presetn)
      fs_q |-> fi_q.params == $past(act_q))
      else $error("frame not taken with active set");

   a_off_restore: assert property (@(posedge pclk) disable iff (!presetn)
      go_off |=> act_q == $past(bak_q) && !seq_q)
      else $error("switch-off did not restore active set");

   a_off_frame_done: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == sss_pkg::ST_FRAME && seq_q |=> seq_q || fb_q == 1'b0)
      else $error("sequencer stopped inside a frame");
endmodule

// ### tb/sss_stepper_tb.sv
// Purpose: self-checking bench for the sequence set stepper
// Assumes: three stored sets, triggers from sss_trig_src
// Notes:   reads and frames are checked against queued expectations
`timescale 1ns/100ps
module sss_stepper_tb;
   logic                pclk, presetn, psel, penable, pwrite, req, rogue;
   logic                pready, pslverr, frame_trig, wait_trig, frame_start, frame_busy;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rnd;
   logic [31:0]         active_params;
   sss_pkg::sss_frame_s frame_info;
   logic [32:0]         rq[$];
   sss_pkg::sss_frame_s fq[$];
   logic [31:0]         s[3];
   int                  error_cnt, checked, cyc;

   sss_stepper #(.NSETS(sss_pkg::MAX_SETS)) sss_stepper_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_trig(frame_trig),
      .wait_trig(wait_trig), .frame_start(frame_start), .frame_busy(frame_busy),
      .frame_info(frame_info), .active_params(active_params));
   sss_trig_src sss_trig_src_inst (.pclk(pclk), .presetn(presetn), .req(req), .rogue(rogue),
      .wait_trig(wait_trig), .frame_trig(frame_trig));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic fail(input string m);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic wrap_up;
      $display("errors %0d, comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk_bit(input logic v, input logic e);
      checked++;
      if (v !== e) fail("flag level");
   endtask
   task automatic chk_word(input logic [31:0] v, input logic [31:0] e);
      checked++;
      if (v !== e) fail("active set");
   endtask
   // one idle cycle after each transfer keeps psel from being set twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no fixed wait count: only the hang guard ends a stalled transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wt(input logic v);
      int n;
      n = 0;
      while (wait_trig !== v && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (wait_trig !== v) fail("status stuck");
   endtask
   // a pending command acts within two cycles of the waiting status, then loads
   task automatic idle;
      wt(1'b1);
      repeat (2) @(posedge pclk);
      wt(1'b1);
   endtask
   task automatic shoot(input logic [5:0] i, input logic [31:0] p);
      fq.push_back('{idx: i, params: p});
      req <= 1'b1;
      @(posedge pclk);
      req <= 1'b0;
      wt(1'b0);
   endtask

   // watcher: takes the oldest note whenever a result appears
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         checked++;
         if (rq.size() == 0) fail("stray read");
         else if ({pslverr, prdata} !== rq.pop_front()) fail("read data");
      end
      if (frame_start === 1'b1) begin
         checked++;
         if (fq.size() == 0) fail("stray frame");
         else if (frame_info !== fq.pop_front()) fail("frame info");
      end
   end
   // hang guard, well above the five frames of the run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         fail("timeout");
         wrap_up;
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      req = 1'b0;
      rogue = 1'b0;
      rnd = 32'he767;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(sss_pkg::OFS_TOTAL, {1'b0, 32'h1});
      rd(8'h18, {1'b1, 32'h0});
      apb(1'b1, sss_pkg::OFS_TOTAL, 32'h50);
      rd(sss_pkg::OFS_TOTAL, {1'b0, 32'h40});
      apb(1'b1, sss_pkg::OFS_TOTAL, 32'h3);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         s[i] = rnd;
         apb(1'b1, sss_pkg::OFS_SIDX, 32'(i));
         apb(1'b1, sss_pkg::OFS_SDATA, rnd);
      end
      rnd = lfsr(rnd);
      apb(1'b1, sss_pkg::OFS_ACT, rnd);
      apb(1'b1, sss_pkg::OFS_CTRL, 32'h1);
      idle;
      rd(sss_pkg::OFS_STAT, {1'b0, 32'h9});
      rd(sss_pkg::OFS_ACT, {1'b0, s[0]});
      shoot(6'h0, s[0]);
      apb(1'b1, sss_pkg::OFS_CTRL, 32'h3);
      rd(sss_pkg::OFS_ACT, {1'b0, s[0]});
      chk_word(active_params, s[0]);
      idle;
      rd(sss_pkg::OFS_ACT, {1'b0, s[1]});
      chk_word(active_params, s[1]);
      shoot(6'h1, s[1]);
      idle;
      apb(1'b1, sss_pkg::OFS_CTRL, 32'h3);
      wt(1'b0);
      rogue <= 1'b1;
      @(posedge pclk);
      rogue <= 1'b0;
      wt(1'b1);
      chk_bit(frame_busy, 1'b0);
      shoot(6'h2, s[2]);
      idle;
      apb(1'b1, sss_pkg::OFS_CTRL, 32'h3);
      idle;
      shoot(6'h0, s[0]);
      idle;
      apb(1'b1, sss_pkg::OFS_CTRL, 32'h3);
      idle;
      // step and rewind arrive only as commands, never from a shared line source
      apb(1'b1, sss_pkg::OFS_CTRL, 32'h5);
      idle;
      shoot(6'h0, s[0]);
      apb(1'b1, sss_pkg::OFS_CTRL, 32'h0);
      chk_bit(frame_busy, 1'b1);
      idle;
      rd(sss_pkg::OFS_ACT, {1'b0, rnd});
      chk_word(active_params, rnd);
      rd(sss_pkg::OFS_STAT, {1'b0, 32'h1});
      if (fq.size() != 0) fail("frame lost");
      wrap_up;
   end
endmodule

// ### tb/sss_trig_src.sv
// Purpose: frame start trigger source facing the stepper
// Assumes: bench requests are one-cycle pulses on req
// Notes:   rogue fires regardless of status, to probe the load window
`timescale 1ns/100ps
module sss_trig_src (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // bench requests
   input  wire logic req,
   input  wire logic rogue,
   // device side
   input  wire logic wait_trig,
   output logic      frame_trig
);
   logic       pend_q;
   logic [2:0] hold_q;
   // four cycles high so the two-flop synchroniser cannot miss the edge
   assign frame_trig = (hold_q != 3'h0);
   // a polite request waits for the waiting status, rogue does not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
         hold_q <= 3'h0;
      end else begin
         if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
         end else if (rogue || (pend_q && wait_trig)) begin
            hold_q <= 3'h4;
            pend_q <= 1'b0;
         end
         if (req) begin
            pend_q <= 1'b1;
         end
      end
   end
endmodule
